/* design/vfb_bounds.sv */
// Purpose: Address and bounds check for one component fetch
// Assumes: buffer state and index are stable while used
// Notes: purely combinational; checks each dword on its own
`timescale 1ns/1ps
`default_nettype none
`include "vfb_params.svh"
module vfb_bounds (
  input wire logic [31:0] start_i, // Buffer start address
  input wire logic [31:0] last_i, // Last byte, or highest index
  input wire logic [11:0] pitch_i, // Structure pitch in bytes
  input wire logic [10:0] ofs_i, // Element offset in structure
  input wire logic [1:0] comp_i, // Component number
  input wire logic [31:0] index_i, // Structure index
  input wire logic null_i, // Buffer is null or absent
  input wire logic legacy_i, // Highest-index checking mode
  output logic [31:0] addr_o, // Byte address of the dword
  output logic zero_o // Return zero instead of reading
);
  logic [32:0] past;
  logic [32:0] tail;

  // Address, first byte past buffer and the zero decision
  always_comb
  begin
    addr_o = start_i + index_i * {20'h0, pitch_i} + {21'h0, ofs_i} +
             {28'h0, comp_i, 2'h0};
    past = {1'b0, last_i} + 33'h1;
    tail = {1'b0, addr_o} + `VFB_DW_BYTES;
    if (legacy_i)
      zero_o = null_i | (last_i != '0 && index_i > last_i);
    else
      zero_o = null_i | (tail > past);
  end
endmodule
`default_nettype wire

/* design/vfb_device.sv */
// Purpose: Vertex fetch device end: decodes buffer and element list
//   commands and packs vertex entries on each draw
// Assumes: the source keeps packets whole and elements contiguous
// Notes: source dwords are stored raw, no format conversion
`timescale 1ns/1ps
`default_nettype none
`include "vfb_params.svh"
module vfb_device #(
  parameter int NBUF = 33, // Vertex buffers held
  parameter int NELEM = 34 // Element descriptors held
) (
  input wire logic CLOCK_I, // Pipeline clock
  input wire logic SRST_I, // Synchronous reset, active high
  vfb_link_if.dev LINK, // Link to the command source
  output logic VE_WE_O, // Vertex entry dword write
  output logic [7:0] VE_SLOT_O, // Dword slot in the entry
  output logic [31:0] VE_DATA_O, // Dword written
  output logic VE_DONE_O, // Vertex entry complete
  output logic CACHE_FLUSH_O, // Overfetch cache invalidate
  output logic [5:0] ELEM_COUNT_O // Descriptors last defined
);
  vfb_pkg::vfb_parse_e p_st;
  vfb_pkg::vfb_fetch_e f_st;
  vfb_pkg::vfb_dword_t d;
  logic [7:0] left_r;
  logic [1:0] pos_r;
  logic [5:0] slot_r;
  logic [5:0] bidx_r;
  logic [5:0] ecnt_r;
  logic [7:0] vs_r;
  logic [5:0] e;
  logic [1:0] c;
  logic [5:0] eb;
  logic [5:0] didx;
  logic [8:0] len1;
  logic take;
  logic e_used;
  logic bsel_ok;
  logic bz;
  logic we_nxt;
  logic [2:0] cc;
  logic [31:0] baddr;
  logic [31:0] idx;
  logic [31:0] addr_r;
  logic [31:0] b_start [0:NBUF-1];
  logic [31:0] b_last [0:NBUF-1];
  logic [11:0] b_pitch [0:NBUF-1];
  logic [NBUF-1:0] b_null;
  logic [NBUF-1:0] b_inst;
  logic [5:0] e_buf [0:NELEM-1];
  logic [10:0] e_ofs [0:NELEM-1];
  logic [11:0] e_cc [0:NELEM-1];
  logic [NELEM-1:0] e_used_r;

  // Value of a generated component
  function automatic logic [31:0] gen_val(input logic [2:0] k);
    unique case (k)
      `VFB_CC_ONE_FP: gen_val = `VFB_ONE_FP;
      `VFB_CC_ONE_INT: gen_val = `VFB_ONE_INT;
      default: gen_val = '0;
    endcase
  endfunction

  // Commands are refused while a draw is in progress
  assign d = LINK.cmd_data;
  assign LINK.cmd_ready = f_st == vfb_pkg::F_IDLE && !LINK.draw_req;
  assign take = LINK.cmd_valid && LINK.cmd_ready;
  assign len1 = {1'b0, d[`VFB_LEN_HI:0]} + 9'h001;
  assign didx = d[`VFB_IDX_HI:`VFB_IDX_LO];

  // Packet parser: header, then payload dwords counted down
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
    begin
      p_st <= vfb_pkg::P_HEAD;
      left_r <= '0;
      pos_r <= '0;
      slot_r <= '0;
      bidx_r <= '0;
    end
    else if (take)
    begin
      unique case (p_st)
        vfb_pkg::P_HEAD:
        begin
          left_r <= d[`VFB_LEN_HI:0];
          pos_r <= '0;
          slot_r <= '0;
          if (vfb_pkg::vfb_is_cmd(d, `VFB_OP_ELEM))
            p_st <= vfb_pkg::P_ELEM;
          else if (vfb_pkg::vfb_is_cmd(d, `VFB_OP_BUF))
            p_st <= vfb_pkg::P_BUF;
          else
            p_st <= vfb_pkg::P_SKIP;
        end
        default:
        begin
          pos_r <= pos_r + 2'h1;
          left_r <= left_r - 8'h01;
          if (p_st == vfb_pkg::P_ELEM && pos_r[0])
            slot_r <= slot_r + 6'h01;
          if (p_st == vfb_pkg::P_BUF && pos_r == '0)
            bidx_r <= didx;
          if (left_r == '0)
            p_st <= vfb_pkg::P_HEAD;
        end
      endcase
    end

  // Element count taken from the header length
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
      ecnt_r <= '0;
    else if (take && p_st == vfb_pkg::P_HEAD &&
             vfb_pkg::vfb_is_cmd(d, `VFB_OP_ELEM))
      ecnt_r <= (int'(len1) / 2 > NELEM) ? 6'(NELEM) :
                6'(len1 >> 1);

  // Buffer state table
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
    begin
      b_null <= '1;
      b_inst <= '0;
    end
    else if (take && p_st == vfb_pkg::P_BUF)
    begin
      if (pos_r == '0 && int'(didx) < NBUF)
      begin
        b_null[didx] <= d[`VFB_NULL_BIT];
        b_inst[didx] <= d[`VFB_ACC_BIT];
        b_pitch[didx] <= d[`VFB_PITCH_HI:0];
      end
      if (pos_r == `VFB_POS_START && int'(bidx_r) < NBUF)
        b_start[bidx_r] <= d;
      if (pos_r == `VFB_POS_LAST && int'(bidx_r) < NBUF)
        b_last[bidx_r] <= d;
    end

  // Invalidate pulse for the overfetch cache
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
      CACHE_FLUSH_O <= 1'b0;
    else
      CACHE_FLUSH_O <= take && p_st == vfb_pkg::P_BUF && pos_r == '0 &&
                       d[`VFB_INV_BIT];

  // Element descriptor table
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
      e_used_r <= '0;
    else if (take && p_st == vfb_pkg::P_ELEM && int'(slot_r) < NELEM)
    begin
      if (!pos_r[0])
      begin
        e_buf[slot_r] <= didx;
        e_used_r[slot_r] <= d[`VFB_VALID_BIT] == `VFB_USED;
        e_ofs[slot_r] <= d[`VFB_OFS_HI:0];
      end
      else
        e_cc[slot_r] <= {vfb_pkg::vfb_cc(d, 3), vfb_pkg::vfb_cc(d, 2),
                         vfb_pkg::vfb_cc(d, 1), vfb_pkg::vfb_cc(d, 0)};
    end

  // Current element and component lookups
  assign e = vs_r[7:2];
  assign c = vs_r[1:0];
  always_comb
  begin
    e_used = e < ecnt_r && e_used_r[e];
    cc = e_cc[e][c * `VFB_CC_W +: `VFB_CC_W];
    eb = e_buf[e];
    bsel_ok = int'(eb) < NBUF;
    idx = (b_inst[eb] == `VFB_ACC_INST) ? LINK.draw_inst :
          LINK.draw_vtx;
  end

  vfb_bounds vfb_bounds_inst (
    .start_i(b_start[eb]),
    .last_i(b_last[eb]),
    .pitch_i(b_pitch[eb]),
    .ofs_i(e_ofs[e]),
    .comp_i(c),
    .index_i(idx),
    .null_i(b_null[eb] | !bsel_ok),
    .legacy_i(LINK.legacy),
    .addr_o(baddr),
    .zero_o(bz)
  );

  // Fetch walk over elements and components; slot is element*4+comp
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
    begin
      f_st <= vfb_pkg::F_IDLE;
      vs_r <= '0;
      addr_r <= '0;
    end
    else
    begin
      unique case (f_st)
        vfb_pkg::F_IDLE:
          if (LINK.draw_req)
          begin
            f_st <= vfb_pkg::F_COMP;
            vs_r <= '0;
          end
        vfb_pkg::F_COMP:
          if (!e_used)
            f_st <= vfb_pkg::F_DONE;
          else if (cc == `VFB_CC_SRC && !bz)
          begin
            f_st <= vfb_pkg::F_WAIT;
            addr_r <= baddr;
          end
          else
            vs_r <= vs_r + 8'h01;
        vfb_pkg::F_WAIT:
          if (LINK.mem_ack)
          begin
            f_st <= vfb_pkg::F_COMP;
            vs_r <= vs_r + 8'h01;
          end
        vfb_pkg::F_DONE:
          f_st <= vfb_pkg::F_IDLE;
      endcase
    end

  // Buffer is consulted only for copied components
  assign we_nxt = (f_st == vfb_pkg::F_COMP && e_used &&
                   cc != `VFB_CC_SKIP &&
                   !(cc == `VFB_CC_SRC && !bz)) ||
                  (f_st == vfb_pkg::F_WAIT && LINK.mem_ack);

  // Vertex entry write port
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
    begin
      VE_WE_O <= 1'b0;
      VE_SLOT_O <= '0;
      VE_DATA_O <= '0;
    end
    else
    begin
      VE_WE_O <= we_nxt;
      if (we_nxt)
      begin
        VE_SLOT_O <= vs_r;
        VE_DATA_O <= (f_st == vfb_pkg::F_WAIT) ? LINK.mem_data :
                     gen_val(cc);
      end
    end

  assign VE_DONE_O = f_st == vfb_pkg::F_DONE;
  assign LINK.draw_done = f_st == vfb_pkg::F_DONE;
  assign LINK.mem_req = f_st == vfb_pkg::F_WAIT;
  assign LINK.mem_addr = addr_r;
  assign ELEM_COUNT_O = ecnt_r;
endmodule
`default_nettype wire

/* design/vfb_source.sv */
// Purpose: Command source end: builds packets from software words,
//   sends them cleaned up, issues draws and serves memory reads
// Assumes: software writes a packet whole before sending it
// Notes: refused orders set the sticky error bit
`timescale 1ns/1ps
`default_nettype none
`include "vfb_params.svh"
module vfb_source #(
  parameter int PKT_WORDS = 69, // Packet buffer depth in dwords
  parameter int MEM_WORDS = 256 // Graphics memory depth in dwords
) (
  input wire logic CLOCK_I, // Pipeline clock
  input wire logic SRST_I, // Synchronous reset, active high
  vfb_link_if.src LINK, // Link to the device
  input wire logic [3:0] REG_ADDR_I, // Register address
  input wire logic [31:0] REG_WDATA_I, // Write data
  input wire logic REG_WR_I, // Write strobe
  input wire logic REG_RD_I, // Read strobe
  output logic [31:0] REG_RDATA_O // Read data, cycle after strobe
);
  localparam int PW = $clog2(PKT_WORDS + 1);
  localparam int MW = $clog2(MEM_WORDS);
  vfb_pkg::vfb_send_e h_st;
  vfb_pkg::vfb_dword_t pkt [0:PKT_WORDS-1];
  logic [31:0] mem [0:MEM_WORDS-1];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW-1:0] j;
  logic [7:0] len;
  logic [MW-1:0] maddr_r;
  logic [31:0] fix;
  logic [31:0] vtx_r;
  logic [31:0] inst_r;
  logic [31:0] mdata_r;
  logic is_el, is_bf, ok, take, last_e, wr_ctl, pkt_we, draw_ok;
  logic send_go, err_set, gap_r, inv_r, err_r, def_r, req_r, ack_r;
  logic legacy_r;

  // Clean one component-control dword
  function automatic vfb_pkg::vfb_dword_t fix_cc(
    input vfb_pkg::vfb_dword_t w, input logic last);
    logic stop;
    logic [2:0] k;
    int b;
    stop = 1'b0;
    for (int n = 0; n < `VFB_COMPS; n++)
    begin
      b = `VFB_CC_LO - n * `VFB_CC_STEP;
      k = vfb_pkg::vfb_cc(w, n);
      if (stop && k == `VFB_CC_SRC)
        k = `VFB_CC_ZERO;
      if (!last && k == `VFB_CC_SKIP)
        k = `VFB_CC_ZERO;
      if (k != `VFB_CC_SRC)
        stop = 1'b1;
      w[b +: `VFB_CC_W] = k;
    end
    fix_cc = w;
  endfunction

  // Packet header decode and whole-packet check
  assign len = pkt[0][`VFB_LEN_HI:0];
  assign is_el = vfb_pkg::vfb_is_cmd(pkt[0], `VFB_OP_ELEM);
  assign is_bf = vfb_pkg::vfb_is_cmd(pkt[0], `VFB_OP_BUF);
  assign ok = int'(wp_r) == int'(len) + 2 &&
              (is_el ? len[0] : (!is_bf || len[1:0] == 2'h3));
  assign j = rp_r - {{(PW-1){1'b0}}, 1'b1};
  assign last_e = int'(j) / 2 == (int'(len) + 1) / 2 - 1;
  assign wr_ctl = REG_WR_I && REG_ADDR_I == `VFB_R_CTRL;
  assign pkt_we = REG_WR_I && REG_ADDR_I == `VFB_R_PKT &&
                  h_st == vfb_pkg::H_IDLE && int'(wp_r) < PKT_WORDS;
  assign send_go = wr_ctl && REG_WDATA_I[`VFB_C_SEND] &&
                   h_st == vfb_pkg::H_IDLE;
  assign draw_ok = REG_WR_I && REG_ADDR_I == `VFB_R_INST && def_r &&
                   !req_r && h_st == vfb_pkg::H_IDLE;
  assign err_set = (send_go && !ok) ||
                   (REG_WR_I && REG_ADDR_I == `VFB_R_INST && !draw_ok);

  // Outgoing dword, cleaned on the way out
  always_comb
  begin
    fix = pkt[rp_r];
    if (rp_r == '0)
    begin
      if (is_el)
        fix[`VFB_MBZ_HI:`VFB_MBZ_LO] = '0;
    end
    else if (is_el && !j[0])
    begin
      if (j == '0)
        fix[`VFB_VALID_BIT] = `VFB_USED;
      else if (gap_r)
        fix[`VFB_VALID_BIT] = `VFB_UNUSED;
    end
    else if (is_el)
      fix = fix_cc(fix, last_e);
    else if (is_bf && j[1:0] == 2'h0 && inv_r)
      fix[`VFB_INV_BIT] = 1'b0;
  end

  assign take = LINK.cmd_valid && LINK.cmd_ready;
  assign LINK.cmd_valid = h_st == vfb_pkg::H_SEND;
  assign LINK.cmd_data = fix;
  assign LINK.legacy = legacy_r;
  assign LINK.draw_req = req_r;
  assign LINK.draw_vtx = vtx_r;
  assign LINK.draw_inst = inst_r;
  assign LINK.mem_ack = ack_r;
  assign LINK.mem_data = mdata_r;

  // Packet buffer storage
  always_ff @(posedge CLOCK_I)
    if (pkt_we)
      pkt[wp_r] <= REG_WDATA_I;

  // Packet fill pointer and mode bit
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
    begin
      wp_r <= '0;
      legacy_r <= 1'b0;
    end
    else if (wr_ctl && h_st == vfb_pkg::H_IDLE)
    begin
      legacy_r <= REG_WDATA_I[`VFB_C_LEGACY];
      if (REG_WDATA_I[`VFB_C_CLEAR])
        wp_r <= '0;
    end
    else if (pkt_we)
      wp_r <= wp_r + {{(PW-1){1'b0}}, 1'b1};

  // Send walk; remembers gaps and invalidates already sent
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
    begin
      h_st <= vfb_pkg::H_IDLE;
      rp_r <= '0;
      gap_r <= 1'b0;
      inv_r <= 1'b0;
      def_r <= 1'b0;
    end
    else if (h_st == vfb_pkg::H_IDLE)
    begin
      if (send_go && ok)
      begin
        h_st <= vfb_pkg::H_SEND;
        rp_r <= '0;
        gap_r <= 1'b0;
        inv_r <= 1'b0;
      end
    end
    else if (take)
    begin
      rp_r <= rp_r + {{(PW-1){1'b0}}, 1'b1};
      if (is_el && rp_r != '0 && !j[0] &&
          fix[`VFB_VALID_BIT] == `VFB_UNUSED)
        gap_r <= 1'b1;
      if (is_bf && rp_r != '0 && j[1:0] == 2'h0 && fix[`VFB_INV_BIT])
        inv_r <= 1'b1;
      if (int'(rp_r) == int'(len) + 1)
      begin
        h_st <= vfb_pkg::H_IDLE;
        if (is_el)
          def_r <= 1'b1;
      end
    end

  // Sticky error; a new refusal wins over the clear
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
      err_r <= 1'b0;
    else if (err_set)
      err_r <= 1'b1;
    else if (wr_ctl && REG_WDATA_I[`VFB_C_CLRERR])
      err_r <= 1'b0;

  // Draw request held until the device reports done
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
    begin
      req_r <= 1'b0;
      vtx_r <= '0;
      inst_r <= '0;
    end
    else
    begin
      if (REG_WR_I && REG_ADDR_I == `VFB_R_VTX && !req_r)
        vtx_r <= REG_WDATA_I;
      if (draw_ok)
      begin
        inst_r <= REG_WDATA_I;
        req_r <= 1'b1;
      end
      else if (LINK.draw_done)
        req_r <= 1'b0;
    end

  // Graphics memory array, loaded by software
  always_ff @(posedge CLOCK_I)
    if (REG_WR_I && REG_ADDR_I == `VFB_R_MDATA)
      mem[maddr_r] <= REG_WDATA_I;

  // Memory answer one cycle after each request
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
    begin
      maddr_r <= '0;
      ack_r <= 1'b0;
      mdata_r <= '0;
    end
    else
    begin
      if (REG_WR_I && REG_ADDR_I == `VFB_R_MADDR)
        maddr_r <= REG_WDATA_I[MW-1:0];
      ack_r <= LINK.mem_req && !ack_r;
      mdata_r <= mem[LINK.mem_addr[MW+`VFB_DW_SHIFT-1:`VFB_DW_SHIFT]];
    end

  // Register read port; data stand one cycle only
  always_ff @(posedge CLOCK_I)
    if (SRST_I)
      REG_RDATA_O <= '0;
    else if (REG_RD_I && REG_ADDR_I == `VFB_R_STAT)
      REG_RDATA_O <= {28'h0, def_r, err_r, req_r,
                      h_st == vfb_pkg::H_SEND};
    else
      REG_RDATA_O <= '0;
endmodule
`default_nettype wire

/* include/vfb_link_if.sv */
// Purpose: Link between command source and vertex fetch device
// Assumes: both ends run on the same pipeline clock
// Notes: commands use valid/ready, draws use req/done, memory reads use req/ack
`timescale 1ns/1ps
`default_nettype none
interface vfb_link_if;
  logic cmd_valid;
  logic cmd_ready;
  logic [31:0] cmd_data;
  logic legacy;
  logic draw_req;
  logic [31:0] draw_vtx;
  logic [31:0] draw_inst;
  logic draw_done;
  logic mem_req;
  logic [31:0] mem_addr;
  logic mem_ack;
  logic [31:0] mem_data;
  modport dev (input cmd_valid, cmd_data, legacy, draw_req, draw_vtx,
               draw_inst, mem_ack, mem_data,
               output cmd_ready, draw_done, mem_req, mem_addr);
  modport src (output cmd_valid, cmd_data, legacy, draw_req, draw_vtx,
               draw_inst, mem_ack, mem_data,
               input cmd_ready, draw_done, mem_req, mem_addr);
endinterface
`default_nettype wire

/* include/vfb_params.svh */
// Purpose: Shared constants of the vertex fetch element state block
// Assumes: included by the package and by every design file
// Notes: the list below names the behaviour kept by the two ends
//
// What this block does
// - Null buffer fetches return zero, no read
// - Invalidate flushes cache; once per packet
// - Access past last byte returns zeros
// - Legacy index above highest index gives zero
// - Highest index zero turns checking off
// - Checked buffers need highest index one+
// - First byte past buffer is last plus one
// - Up to 34 descriptors, valid bit selects
// - Element list recognised by type and opcodes
// - Descriptor count is length plus one, halved
// - Only whole descriptors, at least one
// - Elements defined before any draw
// - Element zero valid, valid ones contiguous
// - Elements sit 128 bits apart in entry
// - Fetch or generate, store one to four; the last element may store none
// - Buffer index field selects source buffer
// - Generated-only elements ignore buffer state
// - Valid bit zero means used, one unused
// - No source copy after non-copy component
// - No unwritten dword holes in entry; skips in the last element are kept as they are
// - Access type picks vertex or instance index
`ifndef VFB_PARAMS_SVH
`define VFB_PARAMS_SVH
`define VFB_TYPE_HI 31
`define VFB_TYPE_LO 29
`define VFB_SUBA_HI 28
`define VFB_SUBA_LO 27
`define VFB_SUBB_HI 26
`define VFB_SUBB_LO 24
`define VFB_OP_HI 23
`define VFB_OP_LO 16
`define VFB_CMD_TYPE 3'h3
`define VFB_SUB_A 2'h3
`define VFB_SUB_B 3'h0
`define VFB_OP_BUF 8'h08
`define VFB_OP_ELEM 8'h09
`define VFB_LEN_HI 7
`define VFB_MBZ_HI 15
`define VFB_MBZ_LO 8
`define VFB_IDX_HI 31
`define VFB_IDX_LO 26
`define VFB_ACC_BIT 20
`define VFB_NULL_BIT 13
`define VFB_INV_BIT 12
`define VFB_PITCH_HI 11
`define VFB_VALID_BIT 25
`define VFB_OFS_HI 10
`define VFB_USED 1'b0
`define VFB_UNUSED 1'b1
`define VFB_ACC_INST 1'b1
`define VFB_POS_START 2'h1
`define VFB_POS_LAST 2'h2
`define VFB_COMPS 4
`define VFB_CC_LO 28
`define VFB_CC_STEP 4
`define VFB_CC_W 3
`define VFB_CC_SKIP 3'h0
`define VFB_CC_SRC 3'h1
`define VFB_CC_ZERO 3'h2
`define VFB_CC_ONE_FP 3'h3
`define VFB_CC_ONE_INT 3'h4
`define VFB_ONE_FP 32'h3f800000
`define VFB_ONE_INT 32'h00000001
`define VFB_DW_BYTES 33'h000000004
`define VFB_DW_SHIFT 2
`define VFB_R_PKT 4'h0
`define VFB_R_CTRL 4'h1
`define VFB_R_VTX 4'h2
`define VFB_R_INST 4'h3
`define VFB_R_STAT 4'h4
`define VFB_R_MADDR 4'h5
`define VFB_R_MDATA 4'h6
`define VFB_C_SEND 0
`define VFB_C_CLEAR 1
`define VFB_C_LEGACY 2
`define VFB_C_CLRERR 3
`endif

/* include/vfb_pkg.sv */
// Purpose: Types and field helpers of the vertex fetch block
// Assumes: vfb_params.svh gives the field positions
// Notes: nothing here holds state
`default_nettype none
`include "vfb_params.svh"
package vfb_pkg;
  typedef logic [31:0] vfb_dword_t;
  typedef enum logic [1:0] {P_HEAD, P_BUF, P_ELEM, P_SKIP} vfb_parse_e;
  typedef enum logic [1:0] {F_IDLE, F_COMP, F_WAIT, F_DONE} vfb_fetch_e;
  typedef enum logic {H_IDLE, H_SEND} vfb_send_e;

  // Header match on type and the three opcode fields
  function automatic logic vfb_is_cmd(input vfb_dword_t d,
                                      input logic [7:0] op);
    vfb_is_cmd = d[`VFB_TYPE_HI:`VFB_TYPE_LO] == `VFB_CMD_TYPE &&
                 d[`VFB_SUBA_HI:`VFB_SUBA_LO] == `VFB_SUB_A &&
                 d[`VFB_SUBB_HI:`VFB_SUBB_LO] == `VFB_SUB_B &&
                 d[`VFB_OP_HI:`VFB_OP_LO] == op;
  endfunction

  // Component control k of a descriptor's second dword
  function automatic logic [2:0] vfb_cc(input vfb_dword_t d,
                                        input int k);
    vfb_cc = d[`VFB_CC_LO - k * `VFB_CC_STEP +: `VFB_CC_W];
  endfunction
endpackage
`default_nettype wire

/* test/test_vertex_fetch_buffer_element_state.sv */
// Purpose: Self-checking bench joining source and device ends
// Assumes: all traffic enters through the source register port
// Notes: vertex entry dwords are gathered by slot number
`timescale 1ns/1ps
`default_nettype none
module test_vertex_fetch_buffer_element_state;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic leg = 1'b0;
  logic [31:0] rdata, ve_data, s;
  logic [31:0] nflush = 32'h0;
  logic ve_we, ve_done, flush;
  logic [7:0] ve_slot;
  logic [5:0] ecount;
  logic [31:0] ve [0:7];
  logic [31:0] ex [0:7];
  int bad_count = 0;
  int num_checks = 0;
  vfb_link_if link();

  // Clock of 20 ns
  always #10 clk = ~clk;
  // Gather entry writes and count flush pulses
  always @(posedge clk)
  begin
    if (ve_we === 1'b1 && ve_slot < 8'h08)
      ve[ve_slot[2:0]] <= ve_data;
    if (flush === 1'b1)
      nflush <= nflush + 32'h1;
  end

  // The two ends and the link checker
  vfb_device #(.NBUF(33), .NELEM(34)) vfb_device_inst (.CLOCK_I(clk),
    .SRST_I(srst), .LINK(link.dev), .VE_WE_O(ve_we), .VE_SLOT_O(ve_slot),
    .VE_DATA_O(ve_data), .VE_DONE_O(ve_done), .CACHE_FLUSH_O(flush),
    .ELEM_COUNT_O(ecount));
  vfb_source vfb_source_inst (.CLOCK_I(clk), .SRST_I(srst),
    .LINK(link.src), .REG_ADDR_I(ra), .REG_WDATA_I(wd), .REG_WR_I(we),
    .REG_RD_I(re), .REG_RDATA_O(rdata));
  vfb_monitor vfb_monitor_inst (.CLOCK_I(clk), .SRST_I(srst),
    .cmd_valid_i(link.cmd_valid), .cmd_ready_i(link.cmd_ready),
    .cmd_data_i(link.cmd_data), .draw_req_i(link.draw_req),
    .draw_done_i(link.draw_done), .mem_req_i(link.mem_req),
    .mem_addr_i(link.mem_addr), .mem_ack_i(link.mem_ack));

  task report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task fail_out();
    bad_count++;
    report_and_stop();
  endtask
  task chk(input string n, input logic [31:0] seen, input logic [31:0] e);
    num_checks++;
    if (seen !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, seen);
    end
  endtask
  // Register port cycles
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    ra <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 s = rdata;
  endtask
  // Wait until nothing is being sent or drawn
  task idle();
    int i;
    for (i = 0; i < 99; i++)
    begin
      rd(4'h4);
      if (s[1:0] === 2'h0)
        break;
    end
    if (i == 99)
      fail_out();
  endtask
  // Load a whole packet and send it
  task pk(input logic [31:0] w[$]);
    wr(4'h1, {29'h0, leg, 2'h2});
    foreach (w[i])
      wr(4'h0, w[i]);
    wr(4'h1, {29'h0, leg, 2'h1});
    idle();
  endtask
  // Draw one vertex and compare the eight first slots
  task draw(input logic [31:0] v, input logic [31:0] n,
    input logic [31:0] e0);
    int i;
    for (i = 0; i < 8; i++)
      ve[i] = 32'hdeadbeef;
    wr(4'h2, v);
    wr(4'h3, n);
    i = 0;
    while (ve_done !== 1'b1 && i < 999)
    begin
      @(posedge clk);
      #1 i++;
    end
    if (i == 999)
      fail_out();
    @(posedge clk);
    #1 ex[0] = e0;
    for (i = 0; i < 8; i++)
      chk("slot", ve[i], ex[i]);
  endtask

  // Draw with no elements is refused
  task t_refuse();
    wr(4'h3, 32'h0);
    rd(4'h4);
    chk("error", s & 32'hc, 32'h4);
    wr(4'h1, 32'h8);
    rd(4'h4);
    chk("error", s & 32'h4, 32'h0);
    pk('{32'h78090002, 32'h0, 32'h0, 32'h0});
    rd(4'h4);
    chk("error", s & 32'hc, 32'h4);
    rd(4'h7);
    chk("unmapped", s, 32'h0);
    $display("t_refuse done");
  endtask
  // Two used elements from buffers 0 and 1
  task t_elem();
    pk('{32'h78090003, 32'h0, 32'h12340000, 32'h04000000, 32'h11110000});
    chk("count", {26'h0, ecount}, 32'h2);
    $display("t_elem done");
  endtask
  // End address bounds, generated values and a null buffer
  task t_plain();
    pk('{32'h78080007, 32'h1008, 32'h0, 32'h7, 32'h0,
      32'h04003010, 32'h40, 32'hff, 32'h0});
    chk("flush", nflush, 32'h1);
    wr(4'h5, 32'h0);
    wr(4'h6, 32'ha0);
    wr(4'h5, 32'h2);
    wr(4'h6, 32'hc2);
    wr(4'h5, 32'h4);
    wr(4'h6, 32'hc4);
    draw(32'h0, 32'h0, 32'ha0);
    draw(32'h1, 32'h0, 32'h0);
    $display("t_plain done");
  endtask
  // Highest index checking, off when zero, instance addressing
  task t_legacy();
    leg = 1'b1;
    pk('{32'h78080003, 32'h8, 32'h0, 32'h1, 32'h0});
    draw(32'h1, 32'h0, 32'hc2);
    draw(32'h2, 32'h0, 32'h0);
    draw(32'hffffffff, 32'h0, 32'h0);
    pk('{32'h78080003, 32'h8, 32'h0, 32'h0, 32'h0});
    draw(32'h2, 32'h0, 32'hc4);
    pk('{32'h78080003, 32'h00100008, 32'h0, 32'h0, 32'h0});
    draw(32'h2, 32'h1, 32'hc2);
    chk("flush", nflush, 32'h1);
    $display("t_legacy done");
  endtask
  // Dirty element list is cleaned; an unused element ends the entry
  task t_clean();
    int k;
    pk('{32'h7809ff03, 32'h02000000, 32'h10140000, 32'h06000000,
      32'h11110000});
    ex[2] = 32'h0;
    for (k = 4; k < 8; k++)
      ex[k] = 32'hdeadbeef;
    draw(32'h0, 32'h1, 32'hc2);
    $display("t_clean done");
  endtask

  // Main sequence
  initial
  begin
    ex = '{32'h0, 32'h0, 32'h3f800000, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_refuse();
    t_elem();
    t_plain();
    t_legacy();
    t_clean();
    report_and_stop();
  end
endmodule
`default_nettype wire

/* test/vfb_monitor.sv */
// Purpose: Link checks between the source and device ends
// Assumes: one clock domain, synchronous reset
// Notes: sees only the shared link signals
`timescale 1ns/1ps
`default_nettype none
module vfb_monitor (
  input wire logic CLOCK_I, // Pipeline clock
  input wire logic SRST_I, // Reset
  input wire logic cmd_valid_i, // Command valid
  input wire logic cmd_ready_i, // Command ready
  input wire logic [31:0] cmd_data_i, // Command word
  input wire logic draw_req_i, // Draw request
  input wire logic draw_done_i, // Draw done pulse
  input wire logic mem_req_i, // Read request
  input wire logic [31:0] mem_addr_i, // Read address
  input wire logic mem_ack_i // Read answer
);
  // All checks share one clock and reset
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  // Command stream handshake and header hygiene
  a_cmd_hold: assert property (cmd_valid_i && !cmd_ready_i |=>
    cmd_valid_i && $stable(cmd_data_i)) else $error("command word dropped");
  a_hdr_clean: assert property (cmd_valid_i &&
    cmd_data_i[31:16] == 16'h7809 |-> cmd_data_i[15:8] == 8'h00)
    else $error("element list header bits not clear");
  a_busy_block: assert property (draw_req_i |-> !cmd_ready_i)
    else $error("command taken during draw");
  // Draw request and completion
  a_draw_ends: assert property ($rose(draw_req_i) |->
    ##[2:999] draw_done_i) else $error("draw never completed");
  a_done_pulse: assert property (draw_done_i |=> !draw_done_i)
    else $error("draw done longer than one cycle");
  a_done_by_req: assert property (draw_done_i |-> draw_req_i)
    else $error("draw done without request");
  // Memory read handshake
  a_mem_hold: assert property (mem_req_i && !mem_ack_i |=>
    mem_req_i && $stable(mem_addr_i)) else $error("read request moved");
  a_ack_on_req: assert property (mem_ack_i |-> $past(mem_req_i))
    else $error("read answer without request");
  // Main scenarios reached
  c_draw: cover property (draw_done_i);
  c_read: cover property (mem_ack_i);
  c_bufs: cover property (cmd_valid_i && cmd_ready_i &&
    cmd_data_i[31:16] == 16'h7808);
endmodule
`default_nettype wire
